// File: logic/tef_edge_watch.sv
// missing-edge detector for the primary_loop reference
// assumes a synchronised reference level and a sample window strobe
`timescale 1ns/1ps
module tef_edge_watch #(
  parameter int MISS = 2
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // reference and expected-edge strobe
  input  wire logic i_ref,
  input  wire logic i_window,
  output logic      o_lost
);
  logic       ref_d, next_ref_d, seen, next_seen;
  logic [3:0] miss, next_miss;

  // count windows closing without a rising edge
  always_comb begin
    next_ref_d = i_ref;
    next_seen  = seen | (i_ref & ~ref_d);
    next_miss  = miss;
    o_lost     = 1'b0;
    if (i_window) begin
      if (next_seen) begin
        next_miss = 4'h0;
      end else if (miss < 4'(MISS)) begin
        next_miss = miss + 4'h1;
        o_lost    = (miss + 4'h1) == 4'(MISS);  // one pulse at 2nd miss
      end
      next_seen = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ref_d <= 1'b0;
      seen  <= 1'b0;
      miss  <= 4'h0;
    end else begin
      ref_d <= next_ref_d;
      seen  <= next_seen;
      miss  <= next_miss;
    end
  end
endmodule

// File: logic/tef_sync3.sv
// three-flop input synchroniser, change accepted when flops 2 and 3 agree
// assumes asynchronous pin inputs and one system clock
`timescale 1ns/1ps
module tef_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  // data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1, s2, s3, next_out;

  // filter: hold old value while flops disagree
  always_comb begin
    next_out = o_sync;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_out[i] = s3[i];
      end
    end
  end

  // registers only; first flop feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      o_sync <= '0;
    end else begin
      s1     <= i_async;
      s2     <= s1;
      s3     <= s2;
      o_sync <= next_out;
    end
  end
endmodule

// File: logic/tef_top.sv
// timing event flags: middle byte of event status plus frequency readout
// assumes an ahb-lite master, one 20 MHz clock, synchronous low reset
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module tef_top
  import tef_pkg::*;
#(
  parameter int NREF = tef_pkg::NUM_REF
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // synchroniser state (same clock)
  input  wire logic [1:0]        i_op_mode,
  input  wire logic [18:0]       i_loop_freq,
  input  wire logic              i_miss_window,
  // reference pins
  input  wire logic              i_primary_ref,
  input  wire logic [NREF-1:0]   i_ref_valid,
  // interrupt
  output logic                   o_irq
);
  import tef_pkg::*;

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  logic [NREF-1:0] valid_s;
  logic            pri_s;
  logic            pri_lost_pulse;

  // reference validity comes from pin-side monitors
  tef_sync3 #(.W(NREF + 1)) tef_sync3_inst (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_primary_ref, i_ref_valid}),
    .o_sync    ({pri_s, valid_s})
  );

  tef_edge_watch #(.MISS(MISS_EDGES)) tef_edge_watch_inst (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ref     (pri_s),
    .i_window  (i_miss_window),
    .o_lost    (pri_lost_pulse)
  );

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  tef_ahb_req_t req;
  logic         ph_wr, ph_rd, next_ph_wr, next_ph_rd;
  logic [7:0]   ph_idx, next_ph_idx;
  logic         take;

  // word index from byte address; used for both reads and writes
  function automatic logic [7:0] word_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  assign req  = '{htrans: i_htrans, haddr: i_haddr, hwrite: i_hwrite,
                  hsize: i_hsize, hsel: i_hsel, hready: i_hready};
  assign take = req.hsel && req.hready &&
                (req.htrans == HTRANS_NONSEQ || req.htrans == HTRANS_SEQ);

  // latch one pending access; slave is always zero-wait
  always_comb begin
    next_ph_wr  = take && req.hwrite;
    next_ph_rd  = take && !req.hwrite;
    next_ph_idx = take ? word_index(req.haddr) : ph_idx;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ph_wr  <= 1'b0;
      ph_rd  <= 1'b0;
      ph_idx <= 8'h00;
    end else begin
      ph_wr  <= next_ph_wr;
      ph_rd  <= next_ph_rd;
      ph_idx <= next_ph_idx;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;  // always okay; unmapped reads zero

  // ****************************************************************
  // event detection
  // ****************************************************************
  logic [1:0]      mode_d, next_mode_d;
  logic [NREF-1:0] valid_d, next_valid_d;
  logic [7:0]      ev;

  always_comb begin
    next_mode_d  = i_op_mode;
    next_valid_d = valid_s;
    ev           = 8'h00;
    ev[BIT_MODE_CHANGE] = (i_op_mode != mode_d);
    ev[BIT_PRI_LOST]    = pri_lost_pulse;
    ev[NREF-1:0]        = valid_s ^ valid_d;
  end

  // ****************************************************************
  // flags, mask, pending summary, frequency snapshot
  // ****************************************************************
  logic [7:0] flags, next_flags;
  logic [7:0] mask, next_mask;
  logic [7:0] pend, next_pend;
  logic [7:0] freq, next_freq;
  logic [7:0] wclr;

  always_comb begin
    wclr = (ph_wr && ph_idx == IDX_FLAGS) ? i_hwdata[7:0] : 8'h00;
    // clear first, then set so a coincident event survives
    next_flags = (flags & ~wclr) | ev;
    next_mask  = (ph_wr && ph_idx == IDX_MASK) ? i_hwdata[7:0] : mask;
    // pending summary: sticky, cleared by its own read
    next_pend  = pend;
    if (ph_rd && ph_idx == IDX_PENDING) begin
      next_pend = 8'h00;
    end
    next_pend  = next_pend | ev;  // a new event outranks the read
    // read-only view of upper loop frequency bits
    next_freq  = {5'h00, i_loop_freq[18:16]};
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      flags   <= RST_FLAGS;
      mask    <= RST_MASK;
      pend    <= 8'h00;
      freq    <= RST_FREQ;
      mode_d  <= 2'h0;
      valid_d <= '0;
    end else begin
      flags   <= next_flags;
      mask    <= next_mask;
      pend    <= next_pend;
      freq    <= next_freq;
      mode_d  <= next_mode_d;
      valid_d <= next_valid_d;
    end
  end

  // level interrupt from unmasked pending bits
  assign o_irq = |(pend & mask);

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rdata, next_rdata;

  // registered mux; writes to the frequency register are ignored
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (take && !req.hwrite) begin
      case (word_index(req.haddr))
        IDX_FREQ_UPPER: next_rdata = {24'h000000, next_freq};
        IDX_FLAGS:      next_rdata = {24'h000000, next_flags};
        IDX_MASK:       next_rdata = {24'h000000, next_mask};
        IDX_PENDING:    next_rdata = {24'h000000, next_pend};
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_hrdata = rdata;
endmodule

// File: pkg/tef_pkg.sv
// package for the timing event flags block: offsets, layouts, reset values
// assumes a 32-bit ahb-lite register bus and a 20 MHz system clock
package tef_pkg;

  // ****************************************************************
  // register offsets (printed 0x07 is not a multiple of four: index)
  // ****************************************************************
  localparam logic [7:0] IDX_FREQ_UPPER = 8'h07;  // loop_frequency_upper
  localparam logic [7:0] IDX_FLAGS      = 8'h08;  // event_flags_middle_byte
  localparam logic [7:0] IDX_MASK       = 8'h09;  // interrupt mask
  localparam logic [7:0] IDX_PENDING    = 8'h0a;  // read-to-clear summary

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int BIT_MODE_CHANGE = 7;
  localparam int BIT_PRI_LOST    = 6;
  localparam int NUM_REF         = 6;
  localparam logic [7:0] RST_FLAGS  = 8'h3f;
  localparam logic [7:0] RST_FREQ   = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam int MISS_EDGES         = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } tef_ahb_req_t;

  typedef struct packed {
    logic          mode_change;
    logic          pri_lost;
    logic [NUM_REF-1:0] ref_change;
  } tef_events_t;

endpackage

// File: test/tb_timing_event_flags.sv
// self-checking bench for tef_top: reads, flag events, interrupts
// assumes package, design and checker files are compiled first
`timescale 1ns/1ps
module tb_timing_event_flags;
  import tef_pkg::*;
  logic        i_clk_sys = 0, i_rst_n = 0, i_hsel = 0, i_hwrite = 0;
  logic        i_miss_window = 0, i_primary_ref = 0, rd_pend = 0;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
  logic [1:0]  i_htrans = 0, i_op_mode = 0;
  logic [2:0]  i_hsize = 3'h2;
  logic [18:0] i_loop_freq = 0;
  logic [5:0]  i_ref_valid = 0;
  logic        o_hreadyout, o_hresp, o_irq;
  logic [15:0] exp_q[$];
  int          bad_count = 0, n_tests = 0, seed = 51;

  tef_top tef_top_inst (.i_clk_sys, .i_rst_n, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout),
    .o_hrdata, .o_hreadyout, .o_hresp, .i_op_mode, .i_loop_freq,
    .i_miss_window, .i_primary_ref, .i_ref_valid, .o_irq);

  always #25 i_clk_sys = ~i_clk_sys;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic fail(input string s);
    bad_count++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // x holds {mask, expected byte}; upper read bits must be zero
  task automatic cmp_rd(input logic [15:0] x);
    n_tests++;
    if ((o_hrdata[7:0] & x[15:8]) !== (x[7:0] & x[15:8])
        || o_hrdata[31:8] !== 24'h0)
      fail("read data mismatch");
  endtask
  task automatic cmp_irq(input logic e);
    n_tests++;
    if (o_irq !== e)
      fail("irq level mismatch");
  endtask
  // one single transfer; ev bumps the mode as the write lands
  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [7:0] d, input logic [15:0] x, input logic ev = 0);
    i_hsel <= 1'b1;
    i_htrans <= HTRANS_NONSEQ;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    if (!w)
      exp_q.push_back(x);
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, d};
    if (ev)
      i_op_mode <= i_op_mode + 2'h1;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
  endtask
  task automatic pulse();
    i_miss_window <= 1'b1;
    tick(1);
    i_miss_window <= 1'b0;
    tick(3);
  endtask

  // read data checked in the data phase against the oldest note
  always @(posedge i_clk_sys) begin
    if (rd_pend)
      cmp_rd(exp_q.pop_front());
    rd_pend <= i_rst_n && i_hsel && i_htrans[1] && !i_hwrite;
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    tick(6000);
    fail("timeout");
    give_verdict();
  end

  initial begin
    i_ref_valid <= 6'($random(seed));
    i_loop_freq <= 19'($random(seed));
    tick(2);
    i_rst_n <= 1'b1;
    xfer(8'h20, 0, 0, 16'hff3f);
    xfer(8'h24, 0, 0, 16'hff00);
    tick(8);
    xfer(8'h20, 1, 8'hff, 0);
    xfer(8'h28, 0, 0, 0);
    xfer(8'h20, 0, 0, 16'hff00);
    // mode steps 0 to 1, 1 to 2 and 2 to 3; a zero write must not clear
    for (int m = 0; m < 3; m++) begin
      i_op_mode <= i_op_mode + 2'h1;
      tick(2);
      xfer(8'h20, 1, 8'h00, 0);
      xfer(8'h20, 0, 0, 16'h8080);
      xfer(8'h20, 1, 8'h80, 0);
      xfer(8'h20, 0, 0, 16'h8000);
    end
    // each reference flips one way, then back
    for (int i = 0; i < 12; i++) begin
      i_ref_valid[i % 6] <= ~i_ref_valid[i % 6];
      tick(8);
      xfer(8'h20, 0, 0, {8'h3f, 8'(1 << (i % 6))});
      xfer(8'h20, 1, 8'h3f, 0);
    end
    // single misses broken by edges must not count
    repeat (3) begin
      pulse();
      i_primary_ref <= 1'b1;
      tick(4);
      i_primary_ref <= 1'b0;
      tick(4);
    end
    xfer(8'h20, 0, 0, 16'h4000);
    repeat (3) pulse();
    xfer(8'h20, 0, 0, 16'h4040);
    xfer(8'h20, 1, 8'hff, 0, 1);
    xfer(8'h20, 0, 0, 16'h8080);
    // pending, mask and the interrupt line
    xfer(8'h28, 0, 0, 0);
    xfer(8'h24, 1, 8'h80, 0);
    xfer(8'h24, 0, 0, 16'hff80);
    i_op_mode <= i_op_mode + 2'h1;
    tick(3);
    cmp_irq(1'b1);
    xfer(8'h28, 0, 0, 16'h8080);
    tick(1);
    cmp_irq(1'b0);
    i_op_mode <= i_op_mode + 2'h1;
    tick(3);
    cmp_irq(1'b1);
    xfer(8'h24, 1, 8'h00, 0);
    // mask lands on the data edge; look once it has settled
    tick(1);
    cmp_irq(1'b0);
    xfer(8'h28, 0, 0, 16'h8080);
    // readout ignores writes and tracks the loop value
    repeat (4) begin
      i_loop_freq <= 19'($random(seed));
      xfer(8'h1c, 1, 8'hff, 0);
      xfer(8'h1c, 0, 0, {8'hff, 5'h0, i_loop_freq[18:16]});
    end
    xfer(8'h30, 0, 0, 16'hff00);
    tick(2);
    give_verdict();
  end
endmodule

bind tef_top tef_monitor tef_monitor_inst (.i_clk_sys, .i_rst_n,
  .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready,
  .o_hrdata, .o_hreadyout, .o_hresp, .i_op_mode, .i_loop_freq, .o_irq);

// File: test/tef_monitor.sv
// checker for tef_top: bus answer, readout and flag behaviour
// assumes a bind from the bench top; sees top-level ports only
`timescale 1ns/1ps
module tef_monitor
  import tef_pkg::*;
(
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  // bus
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  // state and interrupt
  input wire logic [1:0]  i_op_mode,
  input wire logic [18:0] i_loop_freq,
  input wire logic        o_irq
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic rd;
  logic wr;
  // address phases taken this edge
  assign rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  assign wr = i_hsel && i_hready && i_htrans[1] && i_hwrite;
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or okay");
  freq_read_a: assert property (
    rd && i_haddr == 32'h1c |=>
    o_hrdata == {29'h0, $past(i_loop_freq[18:16])})
    else $error("frequency readout wrong");
  read_high_a: assert property (rd |=> o_hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  read_idle_a: assert property (!rd |=> o_hrdata == 32'h0)
    else $error("read data outside data phase");
  mode_set_a: assert property (
    $changed(i_op_mode) ##1 rd && i_haddr == 32'h20 |=> o_hrdata[7])
    else $error("mode change flag missing");
  flag_clear_a: assert property (
    wr && i_haddr == 32'h20 ##1 i_hwdata[7] && $stable(i_op_mode)
    ##1 rd && i_haddr == 32'h20 && $stable(i_op_mode) |=> !o_hrdata[7])
    else $error("flag not cleared by one");
  clear_race_a: assert property (
    wr && i_haddr == 32'h20 ##1 i_hwdata[7] && $changed(i_op_mode)
    ##1 rd && i_haddr == 32'h20 |=> o_hrdata[7])
    else $error("event lost to clear");
  irq_mask_a: assert property (
    wr && i_haddr == 32'h24 ##1 i_hwdata[7:0] == 8'h00 |=> !o_irq)
    else $error("irq while fully masked");
endmodule
